// [bench/adc_front_end_model.sv]
// front end model: answers each convert_start with one conv_done pulse
// assumes the block's core_clk; result is junk outside the done pulse
`timescale 1ns/1ps
`default_nettype none
module adc_front_end_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // from the block
  input wire logic convert_start,
  // to the block
  output logic conv_done,
  output logic [15:0] conv_result,
  // scenario controls
  input wire logic [15:0] value,
  input wire logic [3:0] lat
);
  logic [4:0] cnt;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
      conv_done <= 1'b0;
      conv_result <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (convert_start) begin
        cnt <= {1'b0, lat} + 5'h01;
      end else if (cnt == 5'h01) begin
        conv_done <= 1'b1;
        conv_result <= value;
        cnt <= 5'h00;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // adc_front_end_model
`default_nettype wire

// [bench/adc_sequencing_control_test.sv]
// self-checking bench: apb master, front end model, result queue
// assumes the block's 100 MHz core_clk and zero wait state apb
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control_test;
  import adc_seq_pkg::*;
  localparam int DIV = 2;
  typedef struct {string name; logic [31:0] data; logic err;} note_t;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, event_in = 0;
  logic wake_from_sleep = 0, ref_to_internal = 0, sw_prev = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, input_route_valid, sample_switch_closed, convert_start;
  logic conv_done, irq;
  logic [4:0] input_select_field, c;
  logic [15:0] conv_result, fe_value = 16'h0, v;
  logic [3:0] fe_lat = 4'h0;
  logic [4:0] codes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, MUX_PIN7,
    MUX_PIN10, MUX_PIN11, MUX_INTERNAL_REFERENCE_INPUT, MUX_GND};
  logic [15:0] vals [5] = '{16'h0fff, 16'h1000, 16'h1800, 16'h2000, 16'h2001};
  logic [5:0] rst_idx [6] = '{IDX_DELAY, IDX_WINMODE, IDX_SAMPLE_LENGTH_EXT, IDX_INSEL, IDX_COMMAND,
    IDX_EVENT_TRIGGER_CONTROL};
  int miscompares = 0, total_checks = 0, cyc = 0, sw_rise = 0, sw_len = 0, t0;
  note_t notes [$];
  note_t n;
  always #5 core_clk = ~core_clk;

  adc_sequencing_control #(.ADC_CLK_DIV(DIV)) u_adc_sequencing_control (.core_clk(core_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
    .wake_from_sleep(wake_from_sleep), .ref_to_internal(ref_to_internal),
    .input_select_field(input_select_field), .input_route_valid(input_route_valid),
    .sample_switch_closed(sample_switch_closed), .convert_start(convert_start),
    .conv_done(conv_done), .conv_result(conv_result), .irq(irq));
  adc_front_end_model u_adc_front_end_model (.core_clk(core_clk), .rst(rst),
    .convert_start(convert_start), .conv_done(conv_done), .conv_result(conv_result),
    .value(fe_value), .lat(fe_lat));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task finish_test;
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      chk(n.name, n.data, prdata);
      chk({n.name, " err"}, {31'h0, n.err}, {31'h0, pslverr});
    end
    if (sample_switch_closed === 1'b1 && !sw_prev) sw_rise = cyc;
    if (sample_switch_closed === 1'b1 && !sw_prev) sw_len = 0;
    if (sample_switch_closed === 1'b1) sw_len++;
    sw_prev = sample_switch_closed;
  end
  initial begin
    #300us;
    miscompares++;
    finish_test;
  end

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input string s, input logic [5:0] idx, input logic [31:0] e, input logic r);
    notes.push_back('{s, e, r});
    apb(1'b0, idx, 32'h0);
  endtask
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    chk("irq", 1, {31'h0, irq});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(50976));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rst_idx[i]) rd("reset", rst_idx[i], 0, 0);
    rd("unmapped", 6'h07, 0, 1);
    wr(IDX_WINLO, 32'h1000);
    wr(IDX_WINHI, 32'h2000);
    wr(IDX_IRQMASK, 1);
    wr(IDX_INSEL, 32'h08);
    @(posedge core_clk);
    chk("route", 0, {31'h0, input_route_valid});
    wr(IDX_DELAY, 32'h20);
    wr(IDX_SAMPLE_LENGTH_EXT, 4);
    wr(IDX_CONTROL, 1);
    c = codes[$urandom % 12];
    wr(IDX_INSEL, {27'h0, c});
    @(posedge core_clk);
    chk("insel", {27'h0, c}, {27'h0, input_select_field});
    chk("route", 1, {31'h0, input_route_valid});
    fe_value <= 16'h1800;
    t0 = cyc;
    wr(IDX_COMMAND, 1);
    rd("busy", IDX_COMMAND, 1, 0);
    wr(IDX_INSEL, 32'h1f);
    chk("insel hold", {27'h0, c}, {27'h0, input_select_field});
    wait_irq;
    @(posedge core_clk);
    chk("insel new", 32'h1f, {27'h0, input_select_field});
    chk("startup", 1, {31'h0, sw_rise - t0 >= 16 * DIV && sw_rise - t0 <= 16 * DIV + 8});
    chk("sample len", 1, {31'h0, sw_len >= 6 * DIV && sw_len <= 6 * DIV + 1});
    rd("result", IDX_RESULT, 32'h1800, 0);
    wr(IDX_IRQSTAT, 3);
    for (int m = 0; m < 8; m++) for (int j = 0; j < 5; j++) begin
      v = vals[j];
      fe_value <= v;
      fe_lat <= 4'($urandom);
      wr(IDX_WINMODE, m);
      wr(IDX_COMMAND, 1);
      wait_irq;
      rd("status", IDX_IRQSTAT, {30'h0, (m == 1 || m == 4) && v < 16'h1000 ||
        (m == 2 || m == 4) && v > 16'h2000 || m == 3 && v > 16'h1000 && v < 16'h2000,
        1'b1}, 0);
      rd("result", IDX_RESULT, {16'h0, v}, 0);
      rd("done", IDX_COMMAND, 0, 0);
      wr(IDX_IRQSTAT, 3);
    end
    wr(IDX_EVENT_TRIGGER_CONTROL, 1);
    wr(IDX_DELAY, 32'ha0);
    wake_from_sleep <= 1'b1;
    @(posedge core_clk);
    wake_from_sleep <= 1'b0;
    t0 = cyc;
    event_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    event_in <= 1'b0;
    wait_irq;
    chk("wake delay", 1, {31'h0, sw_rise - t0 >= 256 * DIV && sw_rise - t0 <= 256 * DIV + 12});
    wr(IDX_IRQSTAT, 3);
    wr(IDX_EVENT_TRIGGER_CONTROL, 0);
    wr(IDX_DELAY, 32'hff);
    wr(IDX_SAMPLE_LENGTH_EXT, 31);
    wr(IDX_CONTROL, 3);
    wr(IDX_COMMAND, 1);
    wait_irq;
    rd("wrap", IDX_DELAY, 32'hf0, 0);
    wr(IDX_IRQSTAT, 3);
    wait_irq;
    chk("sample max", 1, {31'h0, sw_len >= 33 * DIV && sw_len <= 33 * DIV + 1});
    rd("step", IDX_DELAY, 32'hf1, 0);
    wr(IDX_CONTROL, 0);
    finish_test;
  end
endmodule // adc_sequencing_control_test
`default_nettype wire

// [logic/adc_seq_pkg.sv]
// constants for the converter sequencing control block
// assumes a 32-bit apb master and one 100 MHz core clock
package adc_seq_pkg;

  // ----------------------------------------
  // register indices, byte address is 4x
  // ----------------------------------------
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_DELAY = 6'h03;
  localparam logic [5:0] IDX_WINMODE = 6'h04;
  localparam logic [5:0] IDX_SAMPLE_LENGTH_EXT = 6'h05;
  localparam logic [5:0] IDX_INSEL = 6'h06;
  localparam logic [5:0] IDX_COMMAND = 6'h08;
  localparam logic [5:0] IDX_EVENT_TRIGGER_CONTROL = 6'h09;
  localparam logic [5:0] IDX_IRQMASK = 6'h0a;
  localparam logic [5:0] IDX_IRQSTAT = 6'h0b;
  localparam logic [5:0] IDX_RESULT = 6'h10;
  localparam logic [5:0] IDX_WINLO = 6'h12;
  localparam logic [5:0] IDX_WINHI = 6'h14;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_FREE_BIT = 1;
  localparam int DLY_AUTO_DELAY_VARIATION_EN_BIT = 4;
  localparam int DLY_SEL_LSB = 5;
  localparam int STAT_RDY_BIT = 0;
  localparam int STAT_WIN_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------
  // window modes and input codes
  // ----------------------------------------
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;
  localparam logic [4:0] MUX_PIN7 = 5'h07;
  localparam logic [4:0] MUX_PIN10 = 5'h0a;
  localparam logic [4:0] MUX_PIN11 = 5'h0b;
  localparam logic [4:0] MUX_INTERNAL_REFERENCE_INPUT = 5'h1d;
  localparam logic [4:0] MUX_GND = 5'h1f;

  // ----------------------------------------
  // timing in converter clock cycles
  // ----------------------------------------
  localparam logic [5:0] SAMPLE_BASE_CYC = 6'h02;
  localparam logic [2:0] INIT_CODE_MAX = 3'h5;
  localparam logic [8:0] INIT_UNIT_CYC = 9'h010;
  localparam int CORE_CLK_MHZ = 100;

  typedef enum logic [2:0] {ST_IDLE, ST_INIT, ST_SAMPLE, ST_CONVERT, ST_SDELAY} seq_state_t;

endpackage

// [logic/adc_sequencing_control.sv]
// sequencing control of a successive approximation converter
// apb slave on core_clk; analog front end answers conv_done on core_clk
//
// Behaviour
// - startup delay codes 0..5 give 0..256 cycles
// - startup delay also after deep sleep wake
// - auto variation adds one delay per sample
// - auto variation wraps delay 15 to 0
// - inter-sample delay equals four-bit field cycles
// - sampling switch open during inter-sample delay
// - window mode selects window flag condition
// - window compares 16-bit result and thresholds
// - sample two cycles plus length field
// - input select codes route pins, reference, ground
// - input select change waits for conversion end
// - start bit write launches a conversion
// - start bit reads busy, clears on completion unless free-running
// - enabled event input starts a conversion
// - window evaluated at each conversion end
// - free-running restarts after each completion
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module adc_sequencing_control
  import adc_seq_pkg::*;
#(
  parameter int ADC_CLK_DIV = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system events
  input wire logic event_in,
  input wire logic wake_from_sleep,
  input wire logic ref_to_internal,
  // analog front end
  output logic [4:0] input_select_field,
  output logic input_route_valid,
  output logic sample_switch_closed,
  output logic convert_start,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic [8:0] cnt;
    logic [7:0] div_cnt;
    logic tick;
    logic ctl_en;
    logic ctl_free;
    logic en_d;
    logic [2:0] startup_delay_sel;
    logic auto_delay_variation_en;
    logic [3:0] inter_sample_delay;
    logic [2:0] window_mode_sel;
    logic [4:0] sample_length_ext;
    logic [4:0] sel_reg;
    logic [4:0] act_mux;
    logic event_start_enable;
    logic [15:0] window_lower_threshold;
    logic [15:0] window_upper_threshold;
    logic [15:0] result;
    logic [1:0] status;
    logic [1:0] mask;
    logic init_pend;
    logic ev_s1;
    logic ev_s2;
    logic ev_d;
    logic sw;
    logic cstart;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [5:0] idx;
  logic mapped;
  logic wr;
  logic ev_edge;
  logic start_req;
  logic win_hit;
  logic [8:0] init_cyc;
  logic [5:0] samp_cyc;

  assign idx = paddr[7:2];
  assign wr = psel && penable && pwrite;
  assign ev_edge = s_reg.ev_s2 && !s_reg.ev_d;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always_comb begin
    case (idx)
      IDX_CONTROL, IDX_DELAY, IDX_WINMODE, IDX_SAMPLE_LENGTH_EXT, IDX_INSEL, IDX_COMMAND,
      IDX_EVENT_TRIGGER_CONTROL, IDX_IRQMASK, IDX_IRQSTAT, IDX_RESULT, IDX_WINLO, IDX_WINHI: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // startup delay and sample length
  // ----------------------------------------
  always_comb begin
    if (s_reg.startup_delay_sel == 3'h0 || s_reg.startup_delay_sel > INIT_CODE_MAX) begin
      init_cyc = 9'h000;
    end else begin
      init_cyc = INIT_UNIT_CYC << (s_reg.startup_delay_sel - 3'h1);
    end
  end

  assign samp_cyc = SAMPLE_BASE_CYC + {1'b0, s_reg.sample_length_ext};

  // ----------------------------------------
  // window compare
  // ----------------------------------------
  always_comb begin
    // full 16-bit compare
    case (s_reg.window_mode_sel)
      WIN_BELOW: win_hit = conv_result < s_reg.window_lower_threshold;
      WIN_ABOVE: win_hit = conv_result > s_reg.window_upper_threshold;
      WIN_INSIDE: win_hit = (conv_result > s_reg.window_lower_threshold)
        && (conv_result < s_reg.window_upper_threshold);
      WIN_OUTSIDE: win_hit = (conv_result < s_reg.window_lower_threshold)
        || (conv_result > s_reg.window_upper_threshold);
      default: win_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.cstart = 1'b0;
    // converter clock enable
    s_next.tick = 1'b0;
    if (s_reg.div_cnt == 8'(ADC_CLK_DIV - 1)) begin
      s_next.div_cnt = 8'h00;
      s_next.tick = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 8'h01;
    end
    // event synchroniser
    s_next.ev_s1 = event_in;
    s_next.ev_s2 = s_reg.ev_s1;
    s_next.ev_d = s_reg.ev_s2;
    s_next.en_d = s_reg.ctl_en;
    // startup delay requests
    if ((s_reg.ctl_en && !s_reg.en_d) || ref_to_internal || wake_from_sleep) begin
      s_next.init_pend = 1'b1;
    end
    start_req = 1'b0;
    if (wr && idx == IDX_COMMAND && pwdata[0]) begin
      start_req = 1'b1;
    end
    if (s_reg.event_start_enable && ev_edge) begin
      start_req = 1'b1;
    end
    // sequencer
    case (s_reg.st)
      ST_IDLE: begin
        s_next.act_mux = s_reg.sel_reg;
        if (start_req && s_reg.ctl_en) begin
          s_next.st = ST_INIT;
          s_next.cnt = s_reg.init_pend ? init_cyc : 9'h000;
          s_next.init_pend = 1'b0;
        end
      end
      ST_INIT, ST_SDELAY: begin
        if (s_reg.cnt == 9'h000) begin
          s_next.st = ST_SAMPLE;
          s_next.cnt = {3'h0, samp_cyc};
        end else if (s_reg.tick) begin
          s_next.cnt = s_reg.cnt - 9'h001;
        end
      end
      ST_SAMPLE: begin
        if (s_reg.cnt == 9'h000) begin
          s_next.st = ST_CONVERT;
          s_next.cstart = 1'b1;
          if (s_reg.auto_delay_variation_en) begin
            s_next.inter_sample_delay = s_reg.inter_sample_delay + 4'h1;
          end
        end else if (s_reg.tick) begin
          s_next.cnt = s_reg.cnt - 9'h001;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          s_next.result = conv_result;
          s_next.act_mux = s_reg.sel_reg;
          if (s_reg.ctl_free) begin
            s_next.st = ST_SDELAY;
            s_next.cnt = {5'h00, s_reg.inter_sample_delay};
          end else begin
            s_next.st = ST_IDLE;
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (!s_reg.ctl_en) begin
      s_next.st = ST_IDLE;
    end
    s_next.sw = (s_next.st == ST_SAMPLE);
    // register writes
    if (wr) begin
      case (idx)
        IDX_CONTROL: begin
          s_next.ctl_en = pwdata[CTL_EN_BIT];
          s_next.ctl_free = pwdata[CTL_FREE_BIT];
        end
        IDX_DELAY: begin
          s_next.startup_delay_sel = pwdata[DLY_SEL_LSB +: 3];
          s_next.auto_delay_variation_en = pwdata[DLY_AUTO_DELAY_VARIATION_EN_BIT];
          s_next.inter_sample_delay = pwdata[3:0];
        end
        IDX_WINMODE: s_next.window_mode_sel = pwdata[2:0];
        IDX_SAMPLE_LENGTH_EXT: s_next.sample_length_ext = pwdata[4:0];
        IDX_INSEL: s_next.sel_reg = pwdata[4:0];
        IDX_EVENT_TRIGGER_CONTROL: s_next.event_start_enable = pwdata[0];
        IDX_IRQMASK: s_next.mask = pwdata[1:0];
        IDX_IRQSTAT: s_next.status = s_reg.status & ~pwdata[1:0];
        IDX_WINLO: s_next.window_lower_threshold = pwdata[15:0];
        IDX_WINHI: s_next.window_upper_threshold = pwdata[15:0];
        default: s_next.rdata = s_next.rdata;
      endcase
    end
    // completion flags, set wins over clear
    if (s_reg.st == ST_CONVERT && conv_done && s_reg.ctl_en) begin
      s_next.status[STAT_RDY_BIT] = 1'b1;
      if (win_hit) begin
        s_next.status[STAT_WIN_BIT] = 1'b1;
      end
    end
    // read data captured in setup phase
    if (psel && !penable) begin
      case (idx)
        IDX_CONTROL: s_next.rdata = {30'h0, s_reg.ctl_free, s_reg.ctl_en};
        IDX_DELAY: s_next.rdata = {24'h0, s_reg.startup_delay_sel,
          s_reg.auto_delay_variation_en, s_reg.inter_sample_delay};
        IDX_WINMODE: s_next.rdata = {29'h0, s_reg.window_mode_sel};
        IDX_SAMPLE_LENGTH_EXT: s_next.rdata = {27'h0, s_reg.sample_length_ext};
        IDX_INSEL: s_next.rdata = {27'h0, s_reg.sel_reg};
        IDX_COMMAND: s_next.rdata = {31'h0, s_reg.st != ST_IDLE};
        IDX_EVENT_TRIGGER_CONTROL: s_next.rdata = {31'h0, s_reg.event_start_enable};
        IDX_IRQMASK: s_next.rdata = {30'h0, s_reg.mask};
        IDX_IRQSTAT: s_next.rdata = {30'h0, s_reg.status};
        IDX_RESULT: s_next.rdata = {16'h0, s_reg.result};
        IDX_WINLO: s_next.rdata = {16'h0, s_reg.window_lower_threshold};
        IDX_WINHI: s_next.rdata = {16'h0, s_reg.window_upper_threshold};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: ST_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign input_select_field = s_reg.act_mux;
  assign sample_switch_closed = s_reg.sw;
  assign convert_start = s_reg.cstart;
  assign irq = |(s_reg.status & s_reg.mask);

  // codes 0..7, 10, 11, 0x1d, 0x1f are routable
  always_comb begin
    input_route_valid = (s_reg.act_mux <= MUX_PIN7) || (s_reg.act_mux == MUX_PIN10)
      || (s_reg.act_mux == MUX_PIN11) || (s_reg.act_mux == MUX_INTERNAL_REFERENCE_INPUT)
      || (s_reg.act_mux == MUX_GND);
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_conv_end;
    s_reg.st == ST_CONVERT && conv_done && s_reg.ctl_en;
  endsequence

  sequence seq_idle_start;
    s_reg.st == ST_IDLE && s_reg.ctl_en && !(wr && idx == IDX_CONTROL);
  endsequence

  a_start_launch: assert property (
    seq_idle_start and (wr && idx == IDX_COMMAND && pwdata[0]) |=> s_reg.st == ST_INIT)
    else $error("start write did not launch");
  a_event_start: assert property (
    seq_idle_start and (s_reg.event_start_enable && ev_edge) |=> s_reg.st == ST_INIT)
    else $error("event did not start");
  a_switch_open: assert property (s_reg.st == ST_SDELAY |-> !sample_switch_closed)
    else $error("switch closed during delay");
  a_delay_step: assert property (s_reg.st == ST_SAMPLE && s_reg.cnt == 9'h000
    && s_reg.auto_delay_variation_en && !(wr && idx == IDX_DELAY)
    |=> s_reg.inter_sample_delay == 4'($past(s_reg.inter_sample_delay) + 4'h1))
    else $error("delay variation step wrong");
  a_delay_wrap: assert property (s_reg.st == ST_SAMPLE && s_reg.cnt == 9'h000
    && s_reg.auto_delay_variation_en && s_reg.inter_sample_delay == 4'hf
    && !(wr && idx == IDX_DELAY) |=> s_reg.inter_sample_delay == 4'h0)
    else $error("delay did not wrap");
  a_sdelay_len: assert property (seq_conv_end and (s_reg.ctl_free
    && !(wr && idx == IDX_CONTROL)) |=> s_reg.cnt == {5'h00, $past(s_reg.inter_sample_delay)})
    else $error("inter-sample delay wrong");
  a_delay_tick: assert property (s_reg.st == ST_SDELAY && s_reg.cnt != 9'h000
    && s_reg.ctl_en |=> s_reg.cnt == $past(s_reg.cnt) - 9'($past(s_reg.tick)))
    else $error("inter-sample delay not counted in ticks");
  a_init_length: assert property ($rose(s_reg.st == ST_INIT) && $past(s_reg.init_pend)
    && $past(s_reg.startup_delay_sel) == 3'h5 |-> s_reg.cnt == 9'h100)
    else $error("startup delay length wrong");
  a_init_zero: assert property ($rose(s_reg.st == ST_INIT)
    && $past(s_reg.startup_delay_sel) > INIT_CODE_MAX |-> s_reg.cnt == 9'h000)
    else $error("reserved startup code delayed");
  a_wake_arm: assert property (wake_from_sleep && !start_req |=> s_reg.init_pend)
    else $error("wake did not arm startup delay");
  a_sample_len: assert property ($rose(s_reg.st == ST_SAMPLE)
    && !$past(wr && idx == IDX_SAMPLE_LENGTH_EXT)
    |-> s_reg.cnt == {4'h0, s_reg.sample_length_ext} + 9'(SAMPLE_BASE_CYC))
    else $error("sample length wrong");
  a_win_below: assert property (seq_conv_end and (s_reg.window_mode_sel == WIN_BELOW
    && conv_result < s_reg.window_lower_threshold) |=> s_reg.status[STAT_WIN_BIT])
    else $error("window flag not set");
  a_win_inside: assert property (seq_conv_end and (s_reg.window_mode_sel == WIN_INSIDE
    && conv_result > s_reg.window_lower_threshold && conv_result < s_reg.window_upper_threshold)
    |=> s_reg.status[STAT_WIN_BIT]) else $error("inside window flag not set");
  a_win_reserved: assert property (seq_conv_end and (s_reg.window_mode_sel > WIN_OUTSIDE
    && !s_reg.status[STAT_WIN_BIT]) |=> !s_reg.status[STAT_WIN_BIT])
    else $error("reserved mode set flag");
  a_mux_hold: assert property (s_reg.st == ST_SAMPLE ##1 s_reg.st == ST_SAMPLE
    |-> $stable(input_select_field)) else $error("input changed mid conversion");
  a_route_reserved: assert property (input_select_field == 5'h08 |-> !input_route_valid)
    else $error("reserved input code routed");
  a_busy_read: assert property (psel && !penable && idx == IDX_COMMAND
    |=> s_reg.rdata == {31'h0, $past(s_reg.st != ST_IDLE)})
    else $error("busy readback wrong");
  a_busy_clear: assert property (seq_conv_end and (!s_reg.ctl_free
    && !(wr && idx == IDX_CONTROL)) |=> s_reg.st == ST_IDLE)
    else $error("busy not cleared");
  a_free_run: assert property (seq_conv_end and (s_reg.ctl_free
    && !(wr && idx == IDX_CONTROL)) |=> s_reg.st == ST_SDELAY
    ##[1:40] (s_reg.st == ST_SAMPLE || !s_reg.ctl_en)) else $error("free run did not restart");

endmodule // adc_sequencing_control

`default_nettype wire
